// *** flash_state_gating_crc_xip_bench.sv ***
// Self-checking bench for the flash command front end
`include "fsx_cfg.svh"

module flash_state_gating_crc_xip_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1, reset_pin_n_in = 1'h1;
	logic reset_pin_enable_in = 1'h1, op_done_in = 1'h0, crc_rd_valid_in;
	logic chip_select_n_in, serial_clock_in, cmd_accept_out, cmd_reject_out;
	logic op_start_out, execute_in_place_out, vcfg_xip_bit_out, crc_busy_out;
	logic crc_fail_flag_out, crc_rd_req_out;
	logic [1:0] proto_width_in = 2'h0;
	logic [2:0] nvcfg_xip_in = 3'h7;
	logic [3:0] data_line_in;
	logic [7:0] crc_rd_data_in, key = 8'h00;
	logic [31:0] crc_rd_addr_out, s;
	logic [63:0] crc_readback_register_out, rb;
	logic [23:0] op_addr_out;
	fsx_pkg::fsx_state_t dev_state_out;
	fsx_pkg::fsx_class_t cmd_class_out;
	int failures = 0, compares = 0, seen, started;
	logic [7:0] wr[4] = '{`FSX_OP_WR_STATUS, `FSX_OP_WR_NVCFG,
		`FSX_OP_OTP_PROG, `FSX_OP_CHIP_ERASE};
	logic [7:0] vol[6] = '{`FSX_OP_WR_VCFG, `FSX_OP_WR_EVCFG, `FSX_OP_WR_ENABLE,
		`FSX_OP_WR_DISABLE, `FSX_OP_CLR_FLAGS, `FSX_OP_WR_LOCK};

	always #2.5 clk_in = ~clk_in;

	fsx_top dut (.clk_in, .rst_in, .ce_in, .chip_select_n_in, .serial_clock_in,
		.data_line_in, .reset_pin_n_in, .reset_pin_enable_in, .proto_width_in,
		.nvcfg_xip_in, .op_done_in, .crc_rd_valid_in, .crc_rd_data_in,
		.cmd_accept_out, .cmd_reject_out, .cmd_class_out, .op_start_out,
		.op_addr_out, .dev_state_out, .execute_in_place_out,
		.vcfg_xip_bit_out, .crc_busy_out, .crc_fail_flag_out,
		.crc_readback_register_out, .crc_rd_req_out, .crc_rd_addr_out);
	fsx_host host (.clk_in, .crc_rd_req_in(crc_rd_req_out),
		.crc_rd_addr_in(crc_rd_addr_out), .key_in(key),
		.chip_select_n_out(chip_select_n_in), .serial_clock_out(serial_clock_in),
		.data_line_out(data_line_in), .crc_rd_valid_out(crc_rd_valid_in),
		.crc_rd_data_out(crc_rd_data_in));

	// ---------------------------------------------
	// Helpers and expectations
	// ---------------------------------------------
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	// Expect 1 accept, 0 refuse, 2 no pulse
	task automatic cmd(input logic [159:0] b, input int n, input int exp);
		seen = 2;
		started = 0;
		host.frame(b, n);
		repeat (10) begin
			@(posedge clk_in);
			if (cmd_accept_out === 1'h1) seen = 1;
			if (cmd_accept_out === 1'h1) rb = crc_readback_register_out;
			if (cmd_reject_out === 1'h1) seen = 0;
			if (op_start_out === 1'h1) started = 1;
		end
		#1 check(seen, exp);
	endtask

	task automatic done_op;
		op_done_in = 1'h1;
		step(1);
		op_done_in = 1'h0;
		step(2);
	endtask

	function automatic logic [7:0] mem_byte(input logic [31:0] a);
		return a[7:0] * 8'h25 ^ key;
	endfunction

	function automatic logic [63:0] crc_byte(input logic [63:0] c,
		input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			c = {c[62:0], 1'h0} ^ ((c[63] ^ d[i]) ? `FSX_CRC_POLY : 64'h0);
		return c;
	endfunction

	task automatic crc_run(input logic [31:0] st, input logic [31:0] e,
		input logic good);
		logic [63:0] c = 64'h0;
		logic [63:0] x;
		logic [151:0] f;
		for (logic [31:0] i = 32'h0; i <= e - st; i++)
			c = crc_byte(c, mem_byte(st + i));
		x = good ? c : c ^ {$urandom, $urandom | 32'h1};
		f = {`FSX_CRC_ACTIVATE, `FSX_CRC_SUBCMD, `FSX_CRC_RANGE_OPT, 128'h0};
		for (int i = 0; i < 8; i++)
			f[127 - 8 * i -: 8] = x[8 * i +: 8];
		for (int i = 0; i < 4; i++) begin
			f[63 - 8 * i -: 8] = st[8 * i +: 8];
			f[31 - 8 * i -: 8] = e[8 * i +: 8];
		end
		cmd(f, 152, 1);
		check(rb, 64'h0);
		for (int i = 0; i < 2000 && crc_busy_out !== 1'h0; i++)
			step(1);
		check(crc_busy_out, 1'h0);
		check(crc_fail_flag_out, !good);
		check(crc_readback_register_out, good ? 64'h0 : c);
	endtask

	task automatic xip_enter;
		cmd({`FSX_OP_WR_VCFG, 8'hF7}, 16, 1);
		check(vcfg_xip_bit_out, 1'h0);
		cmd({`FSX_OP_FAST_READ, 24'h000100, 1'h0}, 33, 1);
		check(execute_in_place_out, 1'h1);
	endtask

	task automatic pin_reset;
		reset_pin_n_in = 1'h0;
		step(4);
		reset_pin_n_in = 1'h1;
		step(6);
	endtask

	task automatic final_report;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#450_000;
		failures++;
		final_report;
	end

	// ---------------------------------------------
	// Tests
	// ---------------------------------------------
	initial begin
		void'($urandom(88141));
		key = 8'($urandom);
		step(8);
		rst_in = 1'h0;
		step(4);
		check(dev_state_out, fsx_pkg::ST_STANDBY);
		check(execute_in_place_out, 1'h0);
		cmd(`FSX_OP_SUSPEND, 8, 0);
		foreach (wr[i]) begin
			cmd({wr[i], 24'hFFFFFF}, 32, 1);
			check(started, 1);
			done_op;
		end
		cmd({`FSX_OP_SEC_ERASE, 24'h120000}, 32, 1);
		check(dev_state_out, fsx_pkg::ST_BUSY);
		cmd({`FSX_OP_READ, 24'h0}, 32, 0);
		cmd(`FSX_OP_RD_STATUS, 8, 1);
		cmd({`FSX_OP_PROGRAM, 24'h300000}, 32, 0);
		foreach (wr[i]) cmd({wr[i], 24'hFFFFFF}, 32, 0);
		foreach (vol[i]) cmd({vol[i], 24'hFFFFFF}, 32, 0);
		check(dev_state_out, fsx_pkg::ST_BUSY);
		cmd(`FSX_OP_SUSPEND, 8, 1);
		check(dev_state_out, fsx_pkg::ST_ERS_SUSP);
		cmd(`FSX_OP_SUSPEND, 8, 0);
		cmd({`FSX_OP_PROGRAM, 24'h1200F0}, 32, 0);
		cmd({`FSX_OP_PROGRAM, 24'h300000}, 32, 1);
		check(op_addr_out, 24'h300000);
		check(cmd_class_out, fsx_pkg::CL_PROGRAM);
		done_op;
		check(dev_state_out, fsx_pkg::ST_ERS_SUSP);
		cmd({`FSX_OP_READ, 24'h120000}, 32, 1);
		cmd({`FSX_OP_SUB_ERASE, 24'h300000}, 32, 0);
		cmd(`FSX_OP_RD_FLAGS, 8, 1);
		foreach (vol[i]) cmd({vol[i], 24'hFFFFFF}, 32, 1);
		cmd(`FSX_OP_RESUME, 8, 1);
		done_op;
		check(dev_state_out, fsx_pkg::ST_STANDBY);
		cmd({`FSX_OP_PROGRAM, 24'h000100}, 32, 1);
		cmd(`FSX_OP_SUSPEND, 8, 1);
		check(dev_state_out, fsx_pkg::ST_PGM_SUSP);
		cmd({`FSX_OP_PROGRAM, 24'h300000}, 32, 0);
		cmd({`FSX_OP_READ, 24'h0}, 32, 1);
		cmd(`FSX_OP_RESUME, 8, 1);
		done_op;
		$display("state gating test done");
		crc_run(32'h40, 32'h40, 1'h0);
		repeat (3) begin
			s = $urandom_range(32'h00FFFF00);
			crc_run(s, s + $urandom_range(15), 1'h1);
		end
		crc_run(s, s + 32'h7, 1'h0);
		$display("range check test done");
		xip_enter;
		cmd({24'h000200, 1'h0}, 25, 2);
		check(execute_in_place_out, 1'h1);
		cmd({24'h000300, 1'h1}, 25, 2);
		check(execute_in_place_out, 1'h0);
		check(vcfg_xip_bit_out, 1'h1);
		xip_enter;
		pin_reset;
		check(execute_in_place_out, 1'h0);
		nvcfg_xip_in = 3'h0;
		proto_width_in = 2'h2;
		pin_reset;
		proto_width_in = 2'h0;
		check(execute_in_place_out, 1'h1);
		cmd({24'h000400, 1'h1}, 25, 2);
		check(execute_in_place_out, 1'h0);
		$display("execute in place test done");
		final_report;
	end
endmodule // flash_state_gating_crc_xip_bench

// *** fsx_cfg.svh ***
// Offsets, codes, reset values and counts of the flash command front end
`ifndef FSX_CFG_SVH
`define FSX_CFG_SVH

// ----------------------------------------------------------------------
// Command codes (plain defaults)
// ----------------------------------------------------------------------
`define FSX_OP_READ 8'h03
`define FSX_OP_FAST_READ 8'h0B
`define FSX_OP_RD_STATUS 8'h05
`define FSX_OP_RD_FLAGS 8'h70
`define FSX_OP_PROGRAM 8'h02
`define FSX_OP_SEC_ERASE 8'hD8
`define FSX_OP_SUB_ERASE 8'h20
`define FSX_OP_WR_STATUS 8'h01
`define FSX_OP_WR_NVCFG 8'hB1
`define FSX_OP_OTP_PROG 8'h42
`define FSX_OP_CHIP_ERASE 8'hC7
`define FSX_OP_WR_VCFG 8'h81
`define FSX_OP_WR_EVCFG 8'h61
`define FSX_OP_WR_ENABLE 8'h06
`define FSX_OP_WR_DISABLE 8'h04
`define FSX_OP_CLR_FLAGS 8'h50
`define FSX_OP_WR_LOCK 8'hE5
`define FSX_OP_SUSPEND 8'h75
`define FSX_OP_RESUME 8'h7A

// ----------------------------------------------------------------------
// Range check sequence
// ----------------------------------------------------------------------
`define FSX_CRC_ACTIVATE 8'h9B
`define FSX_CRC_SUBCMD 8'h27
`define FSX_CRC_RANGE_OPT 8'hFE
`define FSX_CRC_SEQ_BITS 8'h98
`define FSX_CRC_EXP_FIRST 5'h03
`define FSX_CRC_EXP_LAST 5'h0A
`define FSX_CRC_START_FIRST 5'h0B
`define FSX_CRC_START_LAST 5'h0E
`define FSX_CRC_STOP_FIRST 5'h0F
`define FSX_CRC_STOP_LAST 5'h12
`define FSX_CRC_POLY 64'h42F0E1EBA9EA3693
`define FSX_CRC_INIT 64'h0000000000000000

// ----------------------------------------------------------------------
// Frame layout, field positions and reset values
// ----------------------------------------------------------------------
`define FSX_ADDR_END_CMD 8'h20
`define FSX_ADDR_END_XIP 8'h18
`define FSX_OPCODE_BITS 8'h08
`define FSX_BIT_SAT 8'hF0
`define FSX_VCFG_XIP_BIT 3
`define FSX_NVCFG_XIP_OFF 3'h7
`define FSX_SYNC_RST 7'h41
`define FSX_WIDTH_DUAL 2'h1
`define FSX_WIDTH_QUAD 2'h2

`endif

// *** fsx_crc64.sv ***
// Byte-wide CRC-64 accumulator, bits fed from least significant upward
`include "fsx_cfg.svh"

module fsx_crc64 (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic init_in,
	input wire logic en_in,
	input wire logic [7:0] byte_in,
	output logic [63:0] crc_out
);

	logic [63:0] crc_d;

	always_comb begin
		crc_d = crc_out;
		for (int i = 0; i < 8; i++) begin
			if (crc_d[63] ^ byte_in[i]) begin
				crc_d = {crc_d[62:0], 1'b0} ^ `FSX_CRC_POLY;
			end else begin
				crc_d = {crc_d[62:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc_out <= `FSX_CRC_INIT;
		end else if (ce_in) begin
			if (init_in) begin
				crc_out <= `FSX_CRC_INIT;
			end else if (en_in) begin
				crc_out <= crc_d;
			end
		end
	end

endmodule // fsx_crc64

// *** fsx_host.sv ***
// Host controller model driving the serial pins and the array byte port
module fsx_host (
	input wire logic clk_in,
	input wire logic crc_rd_req_in,
	input wire logic [31:0] crc_rd_addr_in,
	input wire logic [7:0] key_in,
	output logic chip_select_n_out = 1'h1,
	output logic serial_clock_out = 1'h0,
	output logic [3:0] data_line_out = 4'hA,
	output logic crc_rd_valid_out = 1'h0,
	output logic [7:0] crc_rd_data_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] a;

	// ---------------------------------------------
	// Frame sender, MSB first, clock idles low
	// ---------------------------------------------
	task automatic frame(input logic [159:0] b, input int n);
		@(posedge clk_in) #1 chip_select_n_out = 1'h0;
		for (int i = n - 1; i >= 0; i--) begin
			data_line_out = {~data_line_out[3:1], b[i]};
			repeat (16) @(posedge clk_in);
			#1 serial_clock_out = 1'h1;
			repeat (16) @(posedge clk_in);
			#1 serial_clock_out = 1'h0;
		end
		repeat (4) @(posedge clk_in);
		#1 chip_select_n_out = 1'h1;
		data_line_out = ~data_line_out;
	endtask

	// ---------------------------------------------
	// Array bytes, answered after zero to three cycles
	// ---------------------------------------------
	always begin
		@(posedge clk_in iff crc_rd_req_in === 1'h1);
		a = crc_rd_addr_in;
		repeat (a[1:0]) @(posedge clk_in);
		#1 crc_rd_valid_out = 1'h1;
		crc_rd_data_out = a[7:0] * 8'h25 ^ key_in;
		@(posedge clk_in) #1 crc_rd_valid_out = 1'h0;
		crc_rd_data_out = ~crc_rd_data_out;
	end
endmodule // fsx_host

// *** fsx_pkg.sv ***
// Types shared by the flash command front end
package fsx_pkg;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'h0,
		ST_BUSY = 2'h1,
		ST_PGM_SUSP = 2'h3,
		ST_ERS_SUSP = 2'h2
	} fsx_state_t;

	typedef enum logic [3:0] {
		CL_NONE = 4'h0,
		CL_READ_MEM = 4'h1,
		CL_READ_STAT = 4'h2,
		CL_PROGRAM = 4'h3,
		CL_ERASE = 4'h4,
		CL_WR_STBY = 4'h5,
		CL_WR_VOL = 4'h6,
		CL_SUSPEND = 4'h7,
		CL_RESUME = 4'h8,
		CL_CRC = 4'h9
	} fsx_class_t;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_REQ = 2'h1,
		CS_WAIT = 2'h3,
		CS_CMP = 2'h2
	} fsx_crc_state_t;

endpackage

// *** fsx_top.sv ***
// Serial flash command acceptance, range checksum and execute-in-place
//
// Notes on behaviour
// - Range check opens with 9Bh, 27h, then FEh selecting a bounded range.
// - Bytes four to eleven give the expected 64-bit checksum, low byte first.
// - Bytes twelve to fifteen give the start byte address, low byte first.
// - Bytes sixteen to nineteen give the stop byte address, low byte first.
// - Checksum work starts only on chip select rising after the last byte.
// - Checksum is CRC-64 ECMA, zero start, each byte fed LSB first.
// - Result compared with expected; pass or fail shown in flag bit four.
// - Readback cleared at check start; holds result only when check fails.
// - One device state at a time; standby takes all but suspend and resume.
// - Sector matters only in erase suspend: no program in suspended sector.
// - Array reads refused while busy, allowed in standby and suspends.
// - Status and flag status reads allowed in every state.
// - Array program allowed only in standby and erase suspend.
// - Sector and subsector erase allowed only from standby.
// - Status, nonvolatile, one-time writes and chip erase only in standby.
// - Volatile writes, enable, flag clear, lock allowed except while busy.
// - Suspend requests taken only while busy, status and nonvolatile writes included.
// - Clear volatile bit three, then confirm bit low in fast read: enter.
// - In execute-in-place each frame starts with address, no opcode.
// - Confirm bit high leaves execute-in-place and sets volatile bit three.
// - Nonvolatile bits eleven to nine select execute-in-place at power-up.
// - Confirm bit is data line zero on first dummy cycle of a fast read.
// - Other data lines are ignored during that first dummy cycle.
// - Reset pin low reloads execute-in-place from nonvolatile bits; in quad only while deselected.
`include "fsx_cfg.svh"

module fsx_top (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic chip_select_n_in,
	input wire logic serial_clock_in,
	input wire logic [3:0] data_line_in,
	input wire logic reset_pin_n_in,
	input wire logic reset_pin_enable_in,
	input wire logic [1:0] proto_width_in,
	input wire logic [2:0] nvcfg_xip_in,
	input wire logic op_done_in,
	input wire logic crc_rd_valid_in,
	input wire logic [7:0] crc_rd_data_in,
	output logic cmd_accept_out,
	output logic cmd_reject_out,
	output fsx_pkg::fsx_class_t cmd_class_out,
	output logic op_start_out,
	output logic [23:0] op_addr_out,
	output fsx_pkg::fsx_state_t dev_state_out,
	output logic execute_in_place_out,
	output logic vcfg_xip_bit_out,
	output logic crc_busy_out,
	output logic crc_fail_flag_out,
	output logic [63:0] crc_readback_register_out,
	output logic crc_rd_req_out,
	output logic [31:0] crc_rd_addr_out
);

	// ------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------
	logic [6:0] sync1_q, sync2_q;
	logic sclk_prev_q, cs_prev_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= `FSX_SYNC_RST;
			sync2_q <= `FSX_SYNC_RST;
			sclk_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else if (ce_in) begin
			sync1_q <= {reset_pin_n_in, data_line_in, serial_clock_in,
				chip_select_n_in};
			sync2_q <= sync1_q;
			sclk_prev_q <= sync2_q[1];
			cs_prev_q <= sync2_q[0];
		end
	end

	wire cs_n_s = sync2_q[0];
	wire sclk_s = sync2_q[1];
	wire [3:0] dq_s = sync2_q[5:2];
	wire data_line_zero = dq_s[0];
	wire reset_pin_n_s = sync2_q[6];
	wire sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
	wire cs_fall = cs_prev_q & ~cs_n_s;
	wire cs_rise = ~cs_prev_q & cs_n_s;
	wire quad = proto_width_in == `FSX_WIDTH_QUAD;
	wire dual = proto_width_in == `FSX_WIDTH_DUAL;

	// ------------------------------------------------------------------
	// Decoding functions
	// ------------------------------------------------------------------
	function automatic fsx_pkg::fsx_class_t fsx_class(input logic [7:0] op);
		case (op)
			`FSX_OP_READ, `FSX_OP_FAST_READ: fsx_class = fsx_pkg::CL_READ_MEM;
			`FSX_OP_RD_STATUS, `FSX_OP_RD_FLAGS:
				fsx_class = fsx_pkg::CL_READ_STAT;
			`FSX_OP_PROGRAM: fsx_class = fsx_pkg::CL_PROGRAM;
			`FSX_OP_SEC_ERASE, `FSX_OP_SUB_ERASE: fsx_class = fsx_pkg::CL_ERASE;
			`FSX_OP_WR_STATUS, `FSX_OP_WR_NVCFG, `FSX_OP_OTP_PROG,
			`FSX_OP_CHIP_ERASE: fsx_class = fsx_pkg::CL_WR_STBY;
			`FSX_OP_WR_VCFG, `FSX_OP_WR_EVCFG, `FSX_OP_WR_ENABLE,
			`FSX_OP_WR_DISABLE, `FSX_OP_CLR_FLAGS, `FSX_OP_WR_LOCK:
				fsx_class = fsx_pkg::CL_WR_VOL;
			`FSX_OP_SUSPEND: fsx_class = fsx_pkg::CL_SUSPEND;
			`FSX_OP_RESUME: fsx_class = fsx_pkg::CL_RESUME;
			`FSX_CRC_ACTIVATE: fsx_class = fsx_pkg::CL_CRC;
			default: fsx_class = fsx_pkg::CL_NONE;
		endcase
	endfunction

	function automatic logic fsx_allowed(input fsx_pkg::fsx_class_t cls,
		input fsx_pkg::fsx_state_t st, input logic susp_hit);
		case (cls)
			fsx_pkg::CL_READ_MEM: fsx_allowed = st != fsx_pkg::ST_BUSY;
			fsx_pkg::CL_READ_STAT: fsx_allowed = 1'b1;
			fsx_pkg::CL_PROGRAM: fsx_allowed = st == fsx_pkg::ST_STANDBY ||
				(st == fsx_pkg::ST_ERS_SUSP && !susp_hit);
			fsx_pkg::CL_ERASE, fsx_pkg::CL_WR_STBY, fsx_pkg::CL_CRC:
				fsx_allowed = st == fsx_pkg::ST_STANDBY;
			fsx_pkg::CL_WR_VOL: fsx_allowed = st != fsx_pkg::ST_BUSY;
			fsx_pkg::CL_SUSPEND: fsx_allowed = st == fsx_pkg::ST_BUSY;
			fsx_pkg::CL_RESUME: fsx_allowed = st == fsx_pkg::ST_PGM_SUSP ||
				st == fsx_pkg::ST_ERS_SUSP;
			default: fsx_allowed = 1'b0;
		endcase
	endfunction

	// ------------------------------------------------------------------
	// Frame shifter
	// ------------------------------------------------------------------
	logic [7:0] bit_cnt_q, shift_q, op_q, data1_q;
	logic [23:0] addr_q;
	logic xip_frame_q, conf_done_q, crc_seq_q, xip_q, vcfg_bit_q;
	logic [63:0] exp_q;
	logic [31:0] start_q, stop_q;

	wire [7:0] step = quad ? 8'h04 : dual ? 8'h02 : 8'h01;
	wire [7:0] next_cnt = bit_cnt_q + step;
	wire [7:0] shift_d = quad ? {shift_q[3:0], dq_s} :
		dual ? {shift_q[5:0], dq_s[1:0]} : {shift_q[6:0], dq_s[0]};
	wire fast_frame = !xip_frame_q && op_q == `FSX_OP_FAST_READ &&
		bit_cnt_q >= `FSX_OPCODE_BITS;
	wire [7:0] addr_end = xip_frame_q ? `FSX_ADDR_END_XIP : `FSX_ADDR_END_CMD;
	wire conf_edge = sclk_rise && (xip_frame_q || fast_frame) &&
		bit_cnt_q == addr_end && !conf_done_q;
	wire byte_edge = sclk_rise && !conf_edge && !conf_done_q &&
		next_cnt[2:0] == 3'h0 && bit_cnt_q < `FSX_BIT_SAT;
	wire [4:0] byte_idx = bit_cnt_q[7:3];
	wire addr_byte = xip_frame_q ? byte_idx < 5'h03 :
		(byte_idx >= 5'h01 && byte_idx <= 5'h03);
	wire in_exp = byte_idx >= `FSX_CRC_EXP_FIRST &&
		byte_idx <= `FSX_CRC_EXP_LAST;
	wire in_start = byte_idx >= `FSX_CRC_START_FIRST &&
		byte_idx <= `FSX_CRC_START_LAST;
	wire in_stop = byte_idx >= `FSX_CRC_STOP_FIRST &&
		byte_idx <= `FSX_CRC_STOP_LAST;
	wire cmd_byte = byte_edge && !xip_frame_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_cnt_q <= 8'h00;
			shift_q <= 8'h00;
			conf_done_q <= 1'b0;
			xip_frame_q <= 1'b0;
		end else if (ce_in) begin
			if (cs_fall) begin
				bit_cnt_q <= 8'h00;
				conf_done_q <= 1'b0;
				xip_frame_q <= xip_q;
			end else if (conf_edge) begin
				conf_done_q <= 1'b1;
			end else if (sclk_rise && bit_cnt_q < `FSX_BIT_SAT) begin
				bit_cnt_q <= next_cnt;
				shift_q <= shift_d;
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			op_q <= 8'h00;
			data1_q <= 8'h00;
			addr_q <= 24'h000000;
			crc_seq_q <= 1'b0;
		end else if (ce_in) begin
			if (cs_fall) begin
				op_q <= 8'h00;
				crc_seq_q <= 1'b0;
			end else if (byte_edge) begin
				if (cmd_byte && byte_idx == 5'h00) begin
					op_q <= shift_d;
				end
				if (cmd_byte && byte_idx == 5'h01) begin
					data1_q <= shift_d;
					crc_seq_q <= op_q == `FSX_CRC_ACTIVATE &&
						shift_d == `FSX_CRC_SUBCMD;
				end
				if (cmd_byte && byte_idx == 5'h02) begin
					crc_seq_q <= crc_seq_q && shift_d == `FSX_CRC_RANGE_OPT;
				end
				if (addr_byte) begin
					addr_q <= {addr_q[15:0], shift_d};
				end
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			exp_q <= 64'h0000000000000000;
			start_q <= 32'h00000000;
			stop_q <= 32'h00000000;
		end else if (ce_in && cmd_byte && crc_seq_q) begin
			if (in_exp) begin
				exp_q <= {shift_d, exp_q[63:8]};
			end
			if (in_start) begin
				start_q <= {shift_d, start_q[31:8]};
			end
			if (in_stop) begin
				stop_q <= {shift_d, stop_q[31:8]};
			end
		end
	end

	// ------------------------------------------------------------------
	// Command decision at deselect
	// ------------------------------------------------------------------
	fsx_pkg::fsx_state_t state_q;
	fsx_pkg::fsx_crc_state_t crc_st_q;
	logic [7:0] ers_sector_q;
	logic ers_kind_q, nest_q, boot_q;

	wire fsx_pkg::fsx_class_t cls = fsx_class(op_q);
	wire susp_hit = addr_q[23:16] == ers_sector_q;
	wire needs_addr = cls == fsx_pkg::CL_READ_MEM ||
		cls == fsx_pkg::CL_PROGRAM || cls == fsx_pkg::CL_ERASE;
	wire complete = cls == fsx_pkg::CL_CRC ?
		(crc_seq_q && bit_cnt_q == `FSX_CRC_SEQ_BITS) :
		(!needs_addr || bit_cnt_q >= `FSX_ADDR_END_CMD);
	wire decide = cs_rise && !xip_frame_q && bit_cnt_q >= `FSX_OPCODE_BITS;
	wire grant = decide && complete && fsx_allowed(cls, state_q, susp_hit) &&
		!(cls == fsx_pkg::CL_CRC && crc_st_q != fsx_pkg::CS_IDLE);
	wire starts_op = cls == fsx_pkg::CL_PROGRAM || cls == fsx_pkg::CL_ERASE ||
		cls == fsx_pkg::CL_WR_STBY;
	wire crc_go = grant && cls == fsx_pkg::CL_CRC;
	wire flag_clear = grant && op_q == `FSX_OP_CLR_FLAGS;
	wire pin_rst = reset_pin_enable_in && !reset_pin_n_s &&
		(!quad || cs_n_s);
	wire load_boot = boot_q || pin_rst;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_accept_out <= 1'b0;
			cmd_reject_out <= 1'b0;
			cmd_class_out <= fsx_pkg::CL_NONE;
			op_start_out <= 1'b0;
			op_addr_out <= 24'h000000;
		end else if (ce_in) begin
			cmd_accept_out <= grant;
			cmd_reject_out <= decide && !grant;
			op_start_out <= grant && starts_op;
			if (decide) begin
				cmd_class_out <= cls;
				op_addr_out <= addr_q;
			end
		end
	end

	// Nested program inside erase suspend returns to erase suspend
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= fsx_pkg::ST_STANDBY;
			ers_sector_q <= 8'h00;
			ers_kind_q <= 1'b0;
			nest_q <= 1'b0;
		end else if (ce_in) begin
			if (pin_rst) begin
				state_q <= fsx_pkg::ST_STANDBY;
				nest_q <= 1'b0;
			end else if (op_done_in && state_q == fsx_pkg::ST_BUSY) begin
				state_q <= nest_q ? fsx_pkg::ST_ERS_SUSP : fsx_pkg::ST_STANDBY;
				nest_q <= 1'b0;
			end else if (grant) begin
				case (cls)
					fsx_pkg::CL_PROGRAM, fsx_pkg::CL_ERASE,
					fsx_pkg::CL_WR_STBY: begin
						state_q <= fsx_pkg::ST_BUSY;
						nest_q <= state_q == fsx_pkg::ST_ERS_SUSP;
						if (state_q == fsx_pkg::ST_STANDBY) begin
							ers_sector_q <= addr_q[23:16];
							ers_kind_q <= op_q == `FSX_OP_SEC_ERASE;
						end
					end
					fsx_pkg::CL_SUSPEND: begin
						state_q <= (ers_kind_q && !nest_q) ?
							fsx_pkg::ST_ERS_SUSP : fsx_pkg::ST_PGM_SUSP;
					end
					fsx_pkg::CL_RESUME: begin
						state_q <= fsx_pkg::ST_BUSY;
					end
					default: begin
						state_q <= state_q;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Execute-in-place control
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			boot_q <= 1'b1;
			xip_q <= 1'b0;
			vcfg_bit_q <= 1'b1;
		end else if (ce_in) begin
			boot_q <= 1'b0;
			if (load_boot) begin
				xip_q <= nvcfg_xip_in != `FSX_NVCFG_XIP_OFF;
				vcfg_bit_q <= 1'b1;
			end else if (conf_edge && xip_frame_q && data_line_zero) begin
				xip_q <= 1'b0;
				vcfg_bit_q <= 1'b1;
			end else if (conf_edge && !xip_frame_q && !vcfg_bit_q &&
				!data_line_zero && state_q != fsx_pkg::ST_BUSY) begin
				xip_q <= 1'b1;
			end else if (grant && op_q == `FSX_OP_WR_VCFG) begin
				vcfg_bit_q <= data1_q[`FSX_VCFG_XIP_BIT];
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dev_state_out <= fsx_pkg::ST_STANDBY;
			execute_in_place_out <= 1'b0;
			vcfg_xip_bit_out <= 1'b1;
			crc_busy_out <= 1'b0;
		end else if (ce_in) begin
			dev_state_out <= state_q;
			execute_in_place_out <= xip_q;
			vcfg_xip_bit_out <= vcfg_bit_q;
			crc_busy_out <= crc_st_q != fsx_pkg::CS_IDLE || crc_go;
		end
	end

	// ------------------------------------------------------------------
	// Range checksum walk
	// ------------------------------------------------------------------
	logic [31:0] cur_q;
	logic [63:0] crc_val;

	wire crc_feed = crc_st_q == fsx_pkg::CS_WAIT && crc_rd_valid_in;
	wire crc_fail = crc_val != exp_q;

	fsx_crc64 u_crc (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.init_in(crc_go),
		.en_in(crc_feed),
		.byte_in(crc_rd_data_in),
		.crc_out(crc_val)
	);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc_st_q <= fsx_pkg::CS_IDLE;
			cur_q <= 32'h00000000;
			crc_rd_req_out <= 1'b0;
			crc_rd_addr_out <= 32'h00000000;
		end else if (ce_in) begin
			crc_rd_req_out <= 1'b0;
			if (pin_rst) begin
				crc_st_q <= fsx_pkg::CS_IDLE;
			end else begin
				case (crc_st_q)
					fsx_pkg::CS_IDLE: if (crc_go) begin
						cur_q <= start_q;
						crc_st_q <= fsx_pkg::CS_REQ;
					end
					fsx_pkg::CS_REQ: begin
						crc_rd_req_out <= 1'b1;
						crc_rd_addr_out <= cur_q;
						crc_st_q <= fsx_pkg::CS_WAIT;
					end
					fsx_pkg::CS_WAIT: if (crc_rd_valid_in) begin
						cur_q <= cur_q + 32'h00000001;
						crc_st_q <= cur_q == stop_q ? fsx_pkg::CS_CMP :
							fsx_pkg::CS_REQ;
					end
					default: crc_st_q <= fsx_pkg::CS_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			crc_fail_flag_out <= 1'b0;
			crc_readback_register_out <= 64'h0000000000000000;
		end else if (ce_in) begin
			if (pin_rst || crc_go) begin
				crc_readback_register_out <= 64'h0000000000000000;
			end else if (crc_st_q == fsx_pkg::CS_CMP) begin
				crc_readback_register_out <= crc_fail ? crc_val :
					64'h0000000000000000;
			end
			if (pin_rst) begin
				crc_fail_flag_out <= 1'b0;
			end else if (crc_st_q == fsx_pkg::CS_CMP) begin
				crc_fail_flag_out <= crc_fail;
			end else if (flag_clear) begin
				crc_fail_flag_out <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	sequence s_confirm_high;
		ce_in && conf_edge && xip_frame_q && data_line_zero && !load_boot;
	endsequence

	sequence s_granted(fsx_pkg::fsx_class_t c);
		cmd_accept_out && cmd_class_out == c;
	endsequence

	chk_suspend_gate: assert property (@(posedge clk_in) disable iff (rst_in)
		s_granted(fsx_pkg::CL_SUSPEND) |-> $past(state_q) == fsx_pkg::ST_BUSY)
		else $error("suspend taken outside busy");
	chk_erase_standby: assert property (@(posedge clk_in) disable iff (rst_in)
		s_granted(fsx_pkg::CL_ERASE) |-> $past(state_q) == fsx_pkg::ST_STANDBY)
		else $error("erase taken outside standby");
	chk_status_always: assert property (@(posedge clk_in) disable iff (rst_in)
		cmd_reject_out |-> cmd_class_out != fsx_pkg::CL_READ_STAT)
		else $error("status read refused");
	chk_busy_read: assert property (@(posedge clk_in) disable iff (rst_in)
		s_granted(fsx_pkg::CL_READ_MEM) |-> $past(state_q) != fsx_pkg::ST_BUSY)
		else $error("array read taken while busy");
	chk_crc_start: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(crc_busy_out) |-> $past(cs_rise) && crc_readback_register_out == 0)
		else $error("checksum start not on deselect");
	chk_crc_result: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && crc_st_q == fsx_pkg::CS_CMP && !pin_rst) |=>
		crc_fail_flag_out == $past(crc_fail) &&
		crc_readback_register_out == ($past(crc_fail) ? $past(crc_val) : 0))
		else $error("checksum result misreported");
	chk_crc_range: assert property (@(posedge clk_in) disable iff (rst_in)
		crc_rd_req_out |-> crc_rd_addr_out >= start_q &&
		crc_rd_addr_out <= stop_q)
		else $error("checksum read outside range");
	chk_xip_exit: assert property (@(posedge clk_in) disable iff (rst_in)
		s_confirm_high |=> !xip_q ##1 !execute_in_place_out && vcfg_xip_bit_out)
		else $error("confirm high did not end execute-in-place");
	chk_reject_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		(ce_in && decide && !grant && !op_done_in && !pin_rst) |=>
		$stable(state_q))
		else $error("refused command changed state");

endmodule // fsx_top
